// ---- design/dssv_volume.sv ----
// Operation
// - Each channel gets a digital gain from 0 dB down to -63.5 dB in 0.5 dB steps.
// - Each channel has its own mute bit, independent of the other channel.
// - A master volume write sets the target gain of both channels at once.
// - With ramping on, applied gain moves one step per sample toward the target and stops there.
// - A slow bit makes the ramp move one step only every second sample.
// - A read-only flag shows that ramping is done and applied gain equals target.
// - A control bit turns ramping off so gain changes apply without stepping.
// - The power-down flag rises only after the ramp and the power-down sequence are done.
// - Toggling de-emphasis or effects ramps to mute, applies the change, then ramps back.
// - At power-up the gain starts muted and ramps up to the target.
// - At power-down the gain ramps to mute before the DAC circuitry is shut down.
// - The whole DAC has its own power bit; each channel's analog section has its own bit but is on only while the DAC is powered.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

module dssv_volume
  import dssv_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Sample stream in
  input wire logic sampleValid,
  input wire dssv_pkg::dssv_sample_s sampleIn,
  // Sample stream out
  output logic outValid,
  output dssv_pkg::dssv_sample_s sampleOut,
  // Processing and power controls
  output logic deemphOn,
  output logic effectsOn,
  output logic dacPowered,
  output logic leftAnalogOn,
  output logic rightAnalogOn
);
  import dssv_pkg::*;

  // ==========================================================
  // Functions
  function automatic logic [15:0] gainMult(input logic [7:0] g);
    logic [15:0] frac;
    logic [3:0] shift;
    frac = 16'h0000;
    shift = 4'(g / 8'(STEPS_PER_OCTAVE));
    unique case (4'(g % 8'(STEPS_PER_OCTAVE)))
      4'h0: frac = 16'h8000;
      4'h1: frac = 16'h78d7;
      4'h2: frac = 16'h7215;
      4'h3: frac = 16'h6bb3;
      4'h4: frac = 16'h65ad;
      4'h5: frac = 16'h5ffd;
      4'h6: frac = 16'h5a9e;
      4'h7: frac = 16'h558c;
      4'h8: frac = 16'h50c3;
      4'h9: frac = 16'h4c3f;
      4'ha: frac = 16'h47fb;
      default: frac = 16'h43f4;
    endcase
    gainMult = g[VOL_MUTE_BIT] ? 16'h0000 : (frac >> shift);
  endfunction

  function automatic logic [15:0] applyGain(input logic [15:0] s, input logic [7:0] g);
    logic signed [32:0] prod;
    prod = $signed(s) * $signed({1'b0, gainMult(g)});
    applyGain = 16'(prod >>> GAIN_FRAC_BITS);
  endfunction

  function automatic logic [7:0] stepToward(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt)
      stepToward = 8'(cur + 8'h01);
    else if (cur > tgt)
      stepToward = 8'(cur - 8'h01);
    else
      stepToward = cur;
  endfunction

  function automatic logic [7:0] volTarget(input logic [7:0] v);
    volTarget = v[VOL_MUTE_BIT] ? GAIN_MUTE : {1'b0, v[6:0]};
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] leftVol;
  logic [7:0] rightVol;
  logic [7:0] ctrl;
  logic [7:0] leftGain;
  logic [7:0] rightGain;
  logic slowPhase;
  dssv_state_e state;
  dssv_state_e next_state;

  wire active = nrst && clkEn;
  wire wrLeft = regWr && (regAddr == ADDR_LEFT_VOL);
  wire wrRight = regWr && (regAddr == ADDR_RIGHT_VOL);
  wire wrMaster = regWr && (regAddr == ADDR_MASTER_VOL);
  wire wrCtrl = regWr && (regAddr == ADDR_CTRL);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      leftVol <= VOL_RESET;
      rightVol <= VOL_RESET;
      ctrl <= CTRL_RESET;
    end
    else if (clkEn)
    begin
      if (wrLeft || wrMaster)
        leftVol <= regWdata[7:0];
      if (wrRight || wrMaster)
        rightVol <= regWdata[7:0];
      if (wrCtrl)
        ctrl <= regWdata[7:0];
    end
  end

  // ==========================================================
  // Sequencer
  wire rampOff = ctrl[CTRL_RAMP_OFF];
  wire rampSlow = ctrl[CTRL_RAMP_SLOW];
  wire pwrReq = ctrl[CTRL_DAC_PWR];
  wire fxChange = (ctrl[CTRL_DEEMPH] != deemphOn) || (ctrl[CTRL_EFFECTS] != effectsOn);
  wire forceMute = (state != DSSV_RUN);
  wire [7:0] leftTarget = forceMute ? GAIN_MUTE : volTarget(leftVol);
  wire [7:0] rightTarget = forceMute ? GAIN_MUTE : volTarget(rightVol);
  wire atMute = (leftGain == GAIN_MUTE) && (rightGain == GAIN_MUTE);
  wire settled = (leftGain == leftTarget) && (rightGain == rightTarget);

  always_comb
  begin
    next_state = state;
    unique case (state)
      DSSV_OFF:
        if (pwrReq)
          next_state = DSSV_RUN;
      DSSV_RUN:
        if (!pwrReq)
          next_state = DSSV_DOWN;
        else if (fxChange)
          next_state = DSSV_FX_MUTE;
      DSSV_FX_MUTE:
        if (!pwrReq)
          next_state = DSSV_DOWN;
        else if (atMute)
          next_state = DSSV_FX_APPLY;
      DSSV_FX_APPLY:
        next_state = DSSV_RUN;
      DSSV_DOWN:
        if (atMute)
          next_state = DSSV_OFF;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state <= DSSV_OFF;
    else if (clkEn)
      state <= next_state;
  end

  // ==========================================================
  // Gain ramp, advanced only on incoming samples
  wire stepNow = sampleValid && (rampOff || !rampSlow || slowPhase);
  wire [7:0] next_leftGain = rampOff ? leftTarget : stepToward(leftGain, leftTarget);
  wire [7:0] next_rightGain = rampOff ? rightTarget : stepToward(rightGain, rightTarget);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      leftGain <= GAIN_MUTE;
      rightGain <= GAIN_MUTE;
      slowPhase <= 1'b0;
    end
    else if (clkEn)
    begin
      if (sampleValid)
        slowPhase <= ~slowPhase;
      if (stepNow)
      begin
        leftGain <= next_leftGain;
        rightGain <= next_rightGain;
      end
    end
  end

  // ==========================================================
  // Sample path and control outputs
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      outValid <= 1'b0;
      sampleOut <= '0;
      deemphOn <= 1'b0;
      effectsOn <= 1'b0;
      dacPowered <= 1'b0;
      leftAnalogOn <= 1'b0;
      rightAnalogOn <= 1'b0;
    end
    else if (clkEn)
    begin
      outValid <= sampleValid && (state != DSSV_OFF);
      if (sampleValid)
      begin
        sampleOut.left <= applyGain(sampleIn.left, leftGain);
        sampleOut.right <= applyGain(sampleIn.right, rightGain);
      end
      if (state == DSSV_FX_APPLY)
      begin
        deemphOn <= ctrl[CTRL_DEEMPH];
        effectsOn <= ctrl[CTRL_EFFECTS];
      end
      dacPowered <= (next_state != DSSV_OFF);
      leftAnalogOn <= (next_state != DSSV_OFF) && ctrl[CTRL_LEFT_PWR];
      rightAnalogOn <= (next_state != DSSV_OFF) && ctrl[CTRL_RIGHT_PWR];
    end
  end

  // ==========================================================
  // Register read, data in the cycle after the strobe
  wire [31:0] statusWord = {8'h00, rightGain, leftGain, 4'h0, effectsOn, deemphOn,
    (state == DSSV_OFF), settled};
  wire [31:0] readMux =
    (regAddr == ADDR_LEFT_VOL) ? {24'h000000, leftVol} :
    (regAddr == ADDR_RIGHT_VOL) ? {24'h000000, rightVol} :
    (regAddr == ADDR_MASTER_VOL) ? {24'h000000, leftVol} :
    (regAddr == ADDR_CTRL) ? {24'h000000, ctrl} :
    (regAddr == ADDR_STATUS) ? statusWord : 32'h00000000;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      regRdata <= 32'h00000000;
    else if (clkEn)
      regRdata <= regRd ? readMux : 32'h00000000;
  end

  // ==========================================================
  // Checks
  sequence sFxMuting;
    (state == DSSV_FX_MUTE) ##1 (state == DSSV_FX_APPLY);
  endsequence

  sequence sFxDone;
    (state == DSSV_RUN) && (deemphOn == $past(ctrl[CTRL_DEEMPH]));
  endsequence

  a_fx_mute_first: assert property (@(posedge core_clk) disable iff (!active)
    sFxMuting |-> $past(atMute))
    else $error("Effects applied before mute reached");

  a_fx_apply_order: assert property (@(posedge core_clk) disable iff (!active)
    (state == DSSV_FX_APPLY) ##1 clkEn |-> sFxDone)
    else $error("Effects change not applied in sequence");

  a_pwr_flag_late: assert property (@(posedge core_clk) disable iff (!active)
    (state == DSSV_DOWN) ##1 (state == DSSV_OFF) |-> $past(atMute))
    else $error("Powered down before reaching mute");

  a_ramp_one_step: assert property (@(posedge core_clk) disable iff (!active)
    !rampOff && $stable(rampOff) |=> (leftGain - $past(leftGain) == 8'h01) ||
    ($past(leftGain) - leftGain == 8'h01) || (leftGain == $past(leftGain)))
    else $error("Left gain moved more than one step");

  a_ramp_needs_sample: assert property (@(posedge core_clk) disable iff (!active)
    !sampleValid |=> $stable(rightGain))
    else $error("Right gain moved without a sample");

  a_slow_half_rate: assert property (@(posedge core_clk) disable iff (!active)
    (!rampOff && rampSlow && sampleValid && leftGain != leftTarget) ##1
    (clkEn && !rampOff && rampSlow && sampleValid && $stable(leftTarget))
    |-> ##1 (leftGain == $past(leftGain, 2)) || ($past(leftGain) == $past(leftGain, 2)))
    else $error("Slow ramp stepped on two samples in a row");

  a_ramp_off_load: assert property (@(posedge core_clk) disable iff (!active)
    rampOff && sampleValid && clkEn |=> (leftGain == $past(leftTarget)) &&
    (rightGain == $past(rightTarget)))
    else $error("Target not loaded with ramp off");

  a_settle_flag: assert property (@(posedge core_clk) disable iff (!active)
    regRd && (regAddr == ADDR_STATUS) |=> regRdata[STAT_SETTLED] ==
    ($past(leftGain == leftTarget) && $past(rightGain == rightTarget)))
    else $error("Settled flag does not match gains");

  a_master_both: assert property (@(posedge core_clk) disable iff (!active)
    wrMaster |=> (leftVol == $past(regWdata[7:0])) && (rightVol == $past(regWdata[7:0])))
    else $error("Master write did not reach both channels");

  a_powerup_muted: assert property (@(posedge core_clk) disable iff (!active)
    (state == DSSV_OFF) |-> atMute || (leftGain == $past(leftGain)))
    else $error("Gain not muted while powered down");

  a_analog_gated: assert property (@(posedge core_clk) disable iff (!active)
    leftAnalogOn |-> dacPowered)
    else $error("Channel analog on with DAC off");

  a_right_analog_gated: assert property (@(posedge core_clk) disable iff (!active)
    rightAnalogOn |-> dacPowered)
    else $error("Right analog on with DAC off");

  a_right_one_step: assert property (@(posedge core_clk) disable iff (!active)
    !rampOff && $stable(rampOff) |=> (rightGain - $past(rightGain) == 8'h01) ||
    ($past(rightGain) - rightGain == 8'h01) || (rightGain == $past(rightGain)))
    else $error("Right gain moved more than one step");

  a_off_no_output: assert property (@(posedge core_clk) disable iff (!active)
    (state == DSSV_OFF) && clkEn |=> !outValid)
    else $error("Sample passed while DAC off");

  a_mute_zero_out: assert property (@(posedge core_clk) disable iff (!active)
    sampleValid && clkEn && rightGain[VOL_MUTE_BIT] |=> (sampleOut.right == 16'h0000))
    else $error("Muted right channel not silent");

  a_fx_apply_muted: assert property (@(posedge core_clk) disable iff (!active)
    (state == DSSV_FX_APPLY) |-> atMute)
    else $error("Effects applied while not muted");

  a_pwr_follows_state: assert property (@(posedge core_clk) disable iff (!active)
    dacPowered == (state != DSSV_OFF))
    else $error("DAC power out of step with sequencer");

  a_powerup_from_mute: assert property (@(posedge core_clk) disable iff (!active)
    (state == DSSV_OFF) ##1 (state == DSSV_RUN) |-> atMute)
    else $error("Power-up did not start from mute");

  a_ramp_off_settled: assert property (@(posedge core_clk) disable iff (!active)
    (rampOff && sampleValid && clkEn) ##1 ($stable(leftTarget) && $stable(rightTarget))
    |-> settled)
    else $error("Settled flag not set at once with ramp off");

  a_master_reads_left: assert property (@(posedge core_clk) disable iff (!active)
    regRd && clkEn && (regAddr == ADDR_MASTER_VOL) |=> (regRdata[7:0] == $past(leftVol)))
    else $error("Master volume read does not show left volume");

  a_read_one_cycle: assert property (@(posedge core_clk) disable iff (!active)
    !regRd && clkEn |=> (regRdata == 32'h00000000))
    else $error("Read data outside its cycle");

  a_fx_hold: assert property (@(posedge core_clk) disable iff (!active)
    (state != DSSV_FX_APPLY) && clkEn |=> $stable(deemphOn) && $stable(effectsOn))
    else $error("Processing changed outside the apply step");

endmodule

// ---- design/dssv_pkg.sv ----
package dssv_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_LEFT_VOL = 8'h00;
  localparam logic [7:0] ADDR_RIGHT_VOL = 8'h04;
  localparam logic [7:0] ADDR_MASTER_VOL = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ==========================================================
  // Volume register fields: bits 6:0 gain code, bit 7 mute
  localparam int VOL_MUTE_BIT = 7;
  localparam logic [7:0] VOL_RESET = 8'h00;
  // Applied gain 128 sits one step below -63.5 dB and means silence
  localparam logic [7:0] GAIN_MUTE = 8'h80;

  // ==========================================================
  // Control register fields
  localparam int CTRL_RAMP_OFF = 0;
  localparam int CTRL_RAMP_SLOW = 1;
  localparam int CTRL_DEEMPH = 2;
  localparam int CTRL_EFFECTS = 3;
  localparam int CTRL_DAC_PWR = 4;
  localparam int CTRL_LEFT_PWR = 5;
  localparam int CTRL_RIGHT_PWR = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // Status register fields
  localparam int STAT_SETTLED = 0;
  localparam int STAT_PWR_DOWN = 1;
  localparam int STAT_DEEMPH = 2;
  localparam int STAT_EFFECTS = 3;
  localparam int STAT_LEFT_GAIN = 8;
  localparam int STAT_RIGHT_GAIN = 16;

  // ==========================================================
  // Gain arithmetic: Q15 multiplier, twelve half-dB steps per 6 dB
  localparam int STEPS_PER_OCTAVE = 12;
  localparam int GAIN_FRAC_BITS = 15;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } dssv_sample_s;

  typedef enum logic [4:0] {
    DSSV_OFF = 5'b00001,
    DSSV_RUN = 5'b00010,
    DSSV_FX_MUTE = 5'b00100,
    DSSV_FX_APPLY = 5'b01000,
    DSSV_DOWN = 5'b10000
  } dssv_state_e;

endpackage

// ---- testbench/dssv_src.sv ----
`timescale 1ns/1ps
// ==========
// Upstream sample source, one stereo sample per request
module dssv_src
  import dssv_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Request from bench
  input wire logic req,
  input wire dssv_pkg::dssv_sample_s dIn,
  // Stream to the block
  output logic sampleValid,
  output dssv_pkg::dssv_sample_s sampleIn
);
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sampleValid <= 1'b0;
      sampleIn <= '0;
    end
    else if (req)
    begin
      sampleValid <= 1'b1;
      sampleIn <= dIn;
    end
    else
    begin
      // Stale data flips so a late capture is caught
      sampleValid <= 1'b0;
      sampleIn <= ~sampleIn;
    end
  end
endmodule

// ---- testbench/dssv_volume_tb.sv ----
`timescale 1ns/1ps
module dssv_volume_tb;
  import dssv_pkg::*;
  logic core_clk, nrst, clkEn, regWr, regRd, req, sampleValid, outValid;
  logic deemphOn, effectsOn, dacPowered, leftAnalogOn, rightAnalogOn;
  logic [7:0] regAddr, code;
  logic [31:0] regWdata, regRdata, rd;
  dssv_sample_s sampleIn, sampleOut, dIn;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  integer seed = 32'ha074;

  dssv_volume u_dut (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sampleValid(sampleValid), .sampleIn(sampleIn), .outValid(outValid),
    .sampleOut(sampleOut), .deemphOn(deemphOn), .effectsOn(effectsOn),
    .dacPowered(dacPowered), .leftAnalogOn(leftAnalogOn), .rightAnalogOn(rightAnalogOn));
  dssv_src u_src (.core_clk(core_clk), .nrst(nrst), .req(req), .dIn(dIn),
    .sampleValid(sampleValid), .sampleIn(sampleIn));

  // ==========
  // Clock never stops, even after power-down
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  // ==========
  // Helpers
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] stat(input logic s, input logic pd, input logic fx,
    input logic [7:0] l);
    return {8'h00, 8'h80, l, 4'h0, fx, fx, pd, s};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= {24'h0, d};
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask

  // Code ff skips the output check; others must be multiples of 12 or mute
  task automatic samp(input int n, input logic [7:0] lc, input logic ov);
    logic signed [15:0] el;
    repeat (n)
    begin
      repeat ($unsigned($random(seed)) % 3) @(posedge core_clk);
      @(posedge core_clk);
      req <= 1'b1;
      dIn <= $random(seed);
      @(posedge core_clk);
      req <= 1'b0;
      @(posedge core_clk);
      #1;
      if (lc != 8'hff)
      begin
        el = (lc == 8'h80) ? 16'sh0 : $signed(dIn.left) >>> (lc / 12);
        chk({31'h0, outValid}, {31'h0, ov});
        chk({16'h0, sampleOut.right}, 32'h0);
        chk({16'h0, sampleOut.left}, {16'h0, el});
      end
    end
  endtask

  // ==========
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    clkEn = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    req = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    dIn = '0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rdr(ADDR_CTRL);
    chk(rd, 32'h0);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b1, 1'b1, 1'b0, 8'h80));
    rdr(8'h14);
    chk(rd, 32'h0);
    // Write while frozen must be lost
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(ADDR_CTRL, 8'h50);
    clkEn <= 1'b1;
    rdr(ADDR_CTRL);
    chk(rd, 32'h0);
    wr(ADDR_LEFT_VOL, 8'h0c);
    wr(ADDR_RIGHT_VOL, 8'h85);
    wr(ADDR_CTRL, 8'h50);
    rdr(ADDR_RIGHT_VOL);
    chk(rd, 32'h85);
    chk({29'h0, dacPowered, leftAnalogOn, rightAnalogOn}, 32'h5);
    wr(ADDR_CTRL, 8'h70);
    for (int k = 1; k <= 3; k++)
    begin
      samp(1, 8'hff, 1'b1);
      rdr(ADDR_STATUS);
      chk(rd, stat(1'b0, 1'b0, 1'b0, 8'h80 - k[7:0]));
    end
    samp(113, 8'hff, 1'b1);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b1, 1'b0, 1'b0, 8'h0c));
    samp(1, 8'h0c, 1'b1);
    // Random master code, ramp off
    wr(ADDR_CTRL, 8'h71);
    code = 8'(12 * ($unsigned($random(seed)) % 11));
    wr(ADDR_MASTER_VOL, code);
    rdr(ADDR_RIGHT_VOL);
    chk(rd, {24'h0, code});
    wr(ADDR_RIGHT_VOL, 8'h80 | code);
    samp(1, 8'hff, 1'b1);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b1, 1'b0, 1'b0, code));
    samp(1, code, 1'b1);
    // Slow ramp: two samples per step
    wr(ADDR_CTRL, 8'h72);
    wr(ADDR_LEFT_VOL, code + 8'd2);
    samp(2, 8'hff, 1'b1);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b0, 1'b0, 1'b0, code + 8'd1));
    samp(2, 8'hff, 1'b1);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b1, 1'b0, 1'b0, code + 8'd2));
    // Effects toggle: mute, apply, unmute
    wr(ADDR_CTRL, 8'h7c);
    samp(1, 8'hff, 1'b1);
    chk({30'h0, deemphOn, effectsOn}, 32'h0);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b0, 1'b0, 1'b0, code + 8'd3));
    samp(260, 8'hff, 1'b1);
    chk({30'h0, deemphOn, effectsOn}, 32'h3);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b1, 1'b0, 1'b1, code + 8'd2));
    // Power-down ramps before shutting off
    wr(ADDR_CTRL, 8'h0c);
    samp(1, 8'hff, 1'b1);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b0, 1'b0, 1'b1, code + 8'd3));
    chk({31'h0, dacPowered}, 32'h1);
    samp(130, 8'hff, 1'b1);
    rdr(ADDR_STATUS);
    chk(rd, stat(1'b1, 1'b1, 1'b1, 8'h80));
    chk({29'h0, dacPowered, leftAnalogOn, rightAnalogOn}, 32'h0);
    samp(1, 8'h80, 1'b0);
    wrap_up();
  end
endmodule
